// >>> design/npe_pkg.sv
/*
 * constants, register map and field layout of the nvm protection block.
 * assumes a single 200 MHz clock domain and an avalon-mm register master.
 */
package npe_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] REG_CFG     = 12'h000;
    localparam logic [11:0] REG_CFG_CLR = 12'h004;
    localparam logic [11:0] REG_PIN     = 12'h008;
    localparam logic [11:0] REG_DBG     = 12'h00C;
    localparam logic [11:0] ID_BASE     = 12'h200;
    localparam logic [11:0] EE_BASE     = 12'h400;
    // ----------------------------------------------------------------
    // configuration bit positions and reset value
    // ----------------------------------------------------------------
    localparam int         CFG_W        = 5;
    localparam int         CFG_RD_PROT  = 0;
    localparam int         CFG_WR_PROT  = 1;
    localparam int         CFG_CFG_PROT = 2;
    localparam int         CFG_DEBUG_N  = 3;
    localparam int         CFG_LV_EN    = 4;
    localparam logic [4:0] CFG_RESET    = 5'h1F;
    // ----------------------------------------------------------------
    // status bits in the config register and pin register
    // ----------------------------------------------------------------
    localparam int ST_PROG_MODE  = 8;
    localparam int ST_HV_SESSION = 9;
    localparam int ST_DEBUG_ON   = 10;
    localparam int PIN_OUT       = 0;
    localparam int PIN_OE        = 1;
    localparam int PIN_IN        = 2;
    localparam int PIN_DEDICATED = 3;
    // ----------------------------------------------------------------
    // programmer request spaces and user id window
    // ----------------------------------------------------------------
    localparam logic [1:0]  SPACE_EE    = 2'h0;
    localparam logic [1:0]  SPACE_CFG   = 2'h1;
    localparam logic [1:0]  SPACE_ID    = 2'h2;
    localparam logic [1:0]  SPACE_ERASE = 2'h3;
    localparam logic [21:0] ID_ADDR_LO  = 22'h200000;
    localparam logic [21:0] ID_ADDR_HI  = 22'h200007;
    localparam int          ID_COUNT    = 8;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    // ----------------------------------------------------------------
    // debugger reservations
    // ----------------------------------------------------------------
    localparam logic [1:0] DBG_PINS       = 2'h3;
    localparam logic [1:0] DBG_STACK_LVLS = 2'h2;
    localparam int         DBG_PROG_BYTES = 576;
    localparam int         DBG_DATA_BYTES = 10;
endpackage

// >>> design/npe_entry_if.sv
/*
 * signals between the protection core and the programming entry logic.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface npe_entry_if;
    logic low_volt_prog_enable;
    logic prog_mode;
    logic hv_session;
    logic pin_in;

    modport core  (output low_volt_prog_enable,
                   input prog_mode, input hv_session, input pin_in);
    modport entry (input low_volt_prog_enable,
                   output prog_mode, output hv_session, output pin_in);
endinterface
`default_nettype wire

// >>> design/npe_prog_entry.sv
/*
 * programming mode entry: synchronises the entry pin and the high voltage
 * detect, opens and closes high or low voltage programming sessions.
 * assumes pins are asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module npe_prog_entry (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // asynchronous pin levels
    input  wire logic prog_entry_pin_in,
    input  wire logic high_voltage_entry_level,
    // core side
    npe_entry_if.entry ent
);
    typedef struct packed {
        logic [1:0] pin_sy;
        logic [1:0] hv_sy;
        logic       prog_mode;
        logic       hv_session;
    } npe_entry_t;

    npe_entry_t st_r;
    npe_entry_t st_nxt;

    // ----------------------------------------------------------------
    // session control
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.pin_sy = {st_r.pin_sy[0], prog_entry_pin_in};
        st_nxt.hv_sy  = {st_r.hv_sy[0], high_voltage_entry_level};
        if (!st_r.prog_mode) begin
            if (st_r.hv_sy[1]) begin
                st_nxt.prog_mode  = 1'b1;
                st_nxt.hv_session = 1'b1;
            end else if (st_r.pin_sy[1] && ent.low_volt_prog_enable) begin
                st_nxt.prog_mode  = 1'b1;
                st_nxt.hv_session = 1'b0;
            end
        end else if (st_r.hv_session ? !st_r.hv_sy[1]
                                     : (!st_r.pin_sy[1] || !ent.low_volt_prog_enable)) begin
            st_nxt.prog_mode  = 1'b0;
            st_nxt.hv_session = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ent.prog_mode  = st_r.prog_mode;
    assign ent.hv_session = st_r.hv_session;
    assign ent.pin_in     = st_r.pin_sy[1];
endmodule // npe_prog_entry
`default_nettype wire

// >>> design/npe_nvm_protect.sv
/*
 * nvm protection core: data eeprom, user id bytes, configuration bits,
 * programmer request port, debugger reservations and avalon-mm slave.
 * assumes one clock, synchronous active low reset, avalon master on clk.
 */
`timescale 1ns/100ps
`default_nettype none
module npe_nvm_protect #(
    parameter int EE_DEPTH       = 256,
    parameter int PROG_MEM_BYTES = 32768,
    parameter int DATA_MEM_BYTES = 2048
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // external programmer request port
    input  wire logic        ext_valid,
    input  wire logic        ext_write,
    input  wire logic [1:0]  ext_space,
    input  wire logic [21:0] ext_addr,
    input  wire logic [7:0]  ext_wdata,
    output var  logic        ext_done,
    output var  logic        ext_refused,
    output var  logic [7:0]  ext_rdata,
    // entry pin and high voltage detect
    input  wire logic        prog_entry_pin_in,
    output var  logic        prog_entry_pin_out,
    output logic             prog_entry_pin_oe,
    input  wire logic        high_voltage_entry_level,
    // debugger reservations
    output var  logic        dbg_enable,
    output var  logic [1:0]  dbg_pins_claimed,
    output var  logic [1:0]  dbg_stack_levels,
    output var  logic [31:0] user_prog_top,
    output var  logic [31:0] user_data_top
);
    localparam int EE_AW = $clog2(EE_DEPTH);

    typedef struct packed {
        logic [npe_pkg::CFG_W-1:0]         cfg;
        logic                              ack;
        logic [31:0]                       rdata;
        logic                              gpio_out;
        logic                              gpio_oe;
        logic                              ext_done;
        logic                              ext_refused;
        logic [7:0]                        ext_rdata;
        logic [npe_pkg::ID_COUNT-1:0][7:0] ids;
        logic [EE_DEPTH-1:0][7:0]          ee;
        logic                              dbg_en;
        logic [31:0]                       prog_top;
        logic [31:0]                       data_top;
    } npe_state_t;

    npe_state_t st_r;
    npe_state_t st_nxt;
    npe_entry_if ent ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] clear_only(input logic [4:0] cur,
                                              input logic [4:0] req,
                                              input logic       keep_cfgp,
                                              input logic       keep_lv_en);
        logic [4:0] res;
        res = cur & req;
        if (keep_cfgp) begin
            res[npe_pkg::CFG_CFG_PROT] = cur[npe_pkg::CFG_CFG_PROT];
        end
        if (keep_lv_en) begin
            res[npe_pkg::CFG_LV_EN] = cur[npe_pkg::CFG_LV_EN];
        end
        return res;
    endfunction

    function automatic logic in_ee(input logic [11:0] a);
        return a >= npe_pkg::EE_BASE && a < (npe_pkg::EE_BASE + 12'(EE_DEPTH * 4));
    endfunction

    function automatic logic in_id(input logic [11:0] a);
        return a >= npe_pkg::ID_BASE
            && a < (npe_pkg::ID_BASE + 12'(npe_pkg::ID_COUNT * 4));
    endfunction

    // ----------------------------------------------------------------
    // entry logic
    // ----------------------------------------------------------------
    npe_prog_entry u_entry (
        .clk                      (clk),
        .reset_n                  (reset_n),
        .prog_entry_pin_in        (prog_entry_pin_in),
        .high_voltage_entry_level (high_voltage_entry_level),
        .ent                      (ent)
    );

    assign ent.low_volt_prog_enable = st_r.cfg[npe_pkg::CFG_LV_EN];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [EE_AW-1:0] cpu_ee_idx;
    logic [2:0]       cpu_id_idx;
    logic [EE_AW-1:0] ext_ee_idx;
    logic [2:0]       ext_id_idx;
    logic             ext_take;
    logic             cfg_locked;
    logic             id_hit;

    always_comb begin
        st_nxt      = st_r;
        cpu_ee_idx  = EE_AW'((avs_address - npe_pkg::EE_BASE) >> 2);
        cpu_id_idx  = 3'((avs_address - npe_pkg::ID_BASE) >> 2);
        ext_ee_idx  = ext_addr[EE_AW-1:0];
        ext_id_idx  = ext_addr[2:0];
        ext_take    = ext_valid && !st_r.ext_done;
        cfg_locked  = !st_r.cfg[npe_pkg::CFG_CFG_PROT];
        id_hit      = ext_addr >= npe_pkg::ID_ADDR_LO && ext_addr <= npe_pkg::ID_ADDR_HI;

        // avalon slave: one wait cycle, then the answer
        st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
        if ((avs_read || avs_write) && !st_r.ack) begin
            st_nxt.rdata = '0;
            if (avs_read) begin
                if (avs_address == npe_pkg::REG_CFG) begin
                    st_nxt.rdata[npe_pkg::CFG_W-1:0]   = st_r.cfg;
                    st_nxt.rdata[npe_pkg::ST_PROG_MODE]  = ent.prog_mode;
                    st_nxt.rdata[npe_pkg::ST_HV_SESSION] = ent.hv_session;
                    st_nxt.rdata[npe_pkg::ST_DEBUG_ON]   = st_r.dbg_en;
                end else if (avs_address == npe_pkg::REG_PIN) begin
                    st_nxt.rdata[npe_pkg::PIN_OUT]       = st_r.gpio_out;
                    st_nxt.rdata[npe_pkg::PIN_OE]        = st_r.gpio_oe;
                    st_nxt.rdata[npe_pkg::PIN_IN]        = ent.pin_in;
                    st_nxt.rdata[npe_pkg::PIN_DEDICATED] = st_r.cfg[npe_pkg::CFG_LV_EN];
                end else if (avs_address == npe_pkg::REG_DBG) begin
                    st_nxt.rdata[1:0] = dbg_stack_levels;
                    st_nxt.rdata[3:2] = dbg_pins_claimed;
                end else if (in_id(avs_address)) begin
                    st_nxt.rdata[7:0] = st_r.ids[cpu_id_idx];
                end else if (in_ee(avs_address)) begin
                    st_nxt.rdata[7:0] = st_r.ee[cpu_ee_idx];
                end
            end
        end

        // avalon writes take effect at the edge that ends the answer cycle
        if (avs_write && st_r.ack) begin
            if (avs_address == npe_pkg::REG_CFG_CLR) begin
                if (!cfg_locked) begin
                    st_nxt.cfg = clear_only(st_r.cfg, avs_writedata[npe_pkg::CFG_W-1:0],
                                            1'b1, 1'b1);
                end
            end else if (avs_address == npe_pkg::REG_PIN) begin
                st_nxt.gpio_out = avs_writedata[npe_pkg::PIN_OUT];
                st_nxt.gpio_oe  = avs_writedata[npe_pkg::PIN_OE];
            end else if (in_id(avs_address)) begin
                st_nxt.ids[cpu_id_idx] = avs_writedata[7:0];
            end else if (in_ee(avs_address)) begin
                st_nxt.ee[cpu_ee_idx] = avs_writedata[7:0];
            end
        end

        // external programmer requests
        st_nxt.ext_done    = ext_take;
        st_nxt.ext_refused = 1'b0;
        if (ext_take) begin
            st_nxt.ext_rdata = '0;
            if (!ent.prog_mode) begin
                st_nxt.ext_refused = 1'b1;
            end else begin
                unique case (ext_space)
                    npe_pkg::SPACE_EE: begin
                        if (ext_addr >= 22'(EE_DEPTH)
                            || !st_r.cfg[npe_pkg::CFG_RD_PROT]) begin
                            st_nxt.ext_refused = 1'b1;
                        end else if (!ext_write) begin
                            st_nxt.ext_rdata = st_r.ee[ext_ee_idx];
                        end else if (!st_r.cfg[npe_pkg::CFG_WR_PROT]) begin
                            st_nxt.ext_refused = 1'b1;
                        end else begin
                            st_nxt.ee[ext_ee_idx] = ext_wdata;
                        end
                    end
                    npe_pkg::SPACE_CFG: begin
                        if (!ext_write) begin
                            st_nxt.ext_rdata[npe_pkg::CFG_W-1:0] = st_r.cfg;
                        end else if (cfg_locked) begin
                            st_nxt.ext_refused = 1'b1;
                        end else begin
                            st_nxt.cfg = clear_only(st_r.cfg, ext_wdata[npe_pkg::CFG_W-1:0],
                                                    1'b0, !ent.hv_session);
                        end
                    end
                    npe_pkg::SPACE_ID: begin
                        if (!id_hit) begin
                            st_nxt.ext_refused = 1'b1;
                        end else if (!ext_write) begin
                            st_nxt.ext_rdata = st_r.ids[ext_id_idx];
                        end else begin
                            st_nxt.ids[ext_id_idx] = ext_wdata;
                        end
                    end
                    npe_pkg::SPACE_ERASE: begin
                        if (!ext_write) begin
                            st_nxt.ext_refused = 1'b1;
                        end else begin
                            st_nxt.cfg = npe_pkg::CFG_RESET;
                            for (int i = 0; i < EE_DEPTH; i++) begin
                                st_nxt.ee[i] = npe_pkg::ERASED_BYTE;
                            end
                            for (int j = 0; j < npe_pkg::ID_COUNT; j++) begin
                                st_nxt.ids[j] = npe_pkg::ERASED_BYTE;
                            end
                        end
                    end
                endcase
            end
        end

        // debugger reservations follow the next-state debug bit, registered in step with cfg
        st_nxt.dbg_en   = !st_nxt.cfg[npe_pkg::CFG_DEBUG_N];
        st_nxt.prog_top = st_nxt.dbg_en ? 32'(PROG_MEM_BYTES - npe_pkg::DBG_PROG_BYTES)
                                        : 32'(PROG_MEM_BYTES);
        st_nxt.data_top = st_nxt.dbg_en ? 32'(DATA_MEM_BYTES - npe_pkg::DBG_DATA_BYTES)
                                        : 32'(DATA_MEM_BYTES);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r          <= '0;
            st_r.cfg      <= npe_pkg::CFG_RESET;
            st_r.ids      <= '1;
            st_r.ee       <= '1;
            st_r.prog_top <= 32'(PROG_MEM_BYTES);
            st_r.data_top <= 32'(DATA_MEM_BYTES);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign avs_waitrequest    = (avs_read || avs_write) && !st_r.ack;
    assign avs_readdata       = st_r.rdata;
    assign ext_done           = st_r.ext_done;
    assign ext_refused        = st_r.ext_refused;
    assign ext_rdata          = st_r.ext_rdata;
    assign prog_entry_pin_out = st_r.gpio_out;
    assign prog_entry_pin_oe  = st_r.gpio_oe && !st_r.cfg[npe_pkg::CFG_LV_EN];
    assign dbg_enable         = st_r.dbg_en;
    assign dbg_pins_claimed   = st_r.dbg_en ? npe_pkg::DBG_PINS : 2'h0;
    assign dbg_stack_levels   = st_r.dbg_en ? npe_pkg::DBG_STACK_LVLS : 2'h0;
    assign user_prog_top      = st_r.prog_top;
    assign user_data_top      = st_r.data_top;
endmodule // npe_nvm_protect
`default_nettype wire

// >>> tb/npe_nvm_protect_props.sv
/* concurrent checks on the nvm protection block ports.
   assumes one clock with reset_n synchronous active low. */
`timescale 1ns/100ps
`default_nettype none
module npe_nvm_protect_props #(
    parameter int EE_DEPTH       = 256,
    parameter int PROG_MEM_BYTES = 32768,
    parameter int DATA_MEM_BYTES = 2048
) (
    // clock, reset and register bus
    input wire logic        clk, reset_n, avs_read, avs_write, avs_waitrequest,
    input wire logic [11:0] avs_address,
    input wire logic [31:0] avs_readdata,
    // programmer port
    input wire logic        ext_valid, ext_write, ext_done, ext_refused,
    input wire logic [1:0]  ext_space,
    input wire logic [21:0] ext_addr,
    input wire logic [7:0]  ext_rdata,
    // pins and debugger
    input wire logic        high_voltage_entry_level, dbg_enable,
    input wire logic [1:0]  dbg_pins_claimed, dbg_stack_levels,
    input wire logic [31:0] user_prog_top, user_data_top
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    done_pulse_a: assert property (ext_valid && !ext_done |=> ext_done ##1 !ext_done)
        else $error("programmer answer not a one cycle pulse");
    refused_done_a: assert property (ext_refused |-> ext_done)
        else $error("refusal without done");
    refused_zero_a: assert property (ext_done && ext_refused && !ext_write |-> ext_rdata == 8'h00)
        else $error("refused read returned data");
    id_range_a: assert property (ext_done && ext_space == npe_pkg::SPACE_ID &&
        !(ext_addr inside {[npe_pkg::ID_ADDR_LO:npe_pkg::ID_ADDR_HI]}) |-> ext_refused)
        else $error("id access outside window accepted");
    id_open_a: assert property (ext_done && !ext_write && ext_space == npe_pkg::SPACE_ID &&
        ext_addr inside {[npe_pkg::ID_ADDR_LO:npe_pkg::ID_ADDR_HI]} &&
        high_voltage_entry_level && $past(high_voltage_entry_level, 6) |-> !ext_refused)
        else $error("id read refused in session");
    ee_range_a: assert property (ext_done && ext_space == npe_pkg::SPACE_EE &&
        ext_addr >= EE_DEPTH |-> ext_refused) else $error("eeprom index out of range accepted");
    dbg_claim_a: assert property (dbg_enable && $past(dbg_enable) |->
        dbg_pins_claimed == 2'h3 && dbg_stack_levels == 2'h2) else $error("debug claims wrong");
    dbg_top_a: assert property (dbg_enable && $past(dbg_enable) |->
        user_prog_top == PROG_MEM_BYTES - 576 && user_data_top == DATA_MEM_BYTES - 10)
        else $error("debug memory tops wrong");
    full_top_a: assert property (!dbg_enable && !$past(dbg_enable) |->
        user_prog_top == PROG_MEM_BYTES && user_data_top == DATA_MEM_BYTES)
        else $error("memory tops reduced without debug");
    unmapped_a: assert property (avs_read && !avs_waitrequest &&
        avs_address inside {[12'h010:12'h1FC]} |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // npe_nvm_protect_props
bind npe_nvm_protect npe_nvm_protect_props #(.EE_DEPTH(EE_DEPTH),
    .PROG_MEM_BYTES(PROG_MEM_BYTES), .DATA_MEM_BYTES(DATA_MEM_BYTES)) i_npe_nvm_protect_props (
    .clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .avs_address, .avs_readdata,
    .ext_valid, .ext_write, .ext_done, .ext_refused, .ext_space, .ext_addr, .ext_rdata,
    .high_voltage_entry_level, .dbg_enable, .dbg_pins_claimed, .dbg_stack_levels,
    .user_prog_top, .user_data_top);
`default_nettype wire

// >>> tb/npe_prog_model.sv
/* external programmer model: byte requests and entry pin levels.
   assumes the bench calls its tasks; answers sampled at rising edges. */
`timescale 1ns/100ps
`default_nettype none
module npe_prog_model (
    // clock
    input wire logic        clk,
    // request side
    output var logic        ext_valid, ext_write,
    output var logic [1:0]  ext_space,
    output var logic [21:0] ext_addr,
    output var logic [7:0]  ext_wdata,
    // answer side
    input wire logic        ext_done, ext_refused,
    input wire logic [7:0]  ext_rdata,
    // pins
    output var logic        prog_entry_pin_in, high_voltage_entry_level
);
    initial begin
        ext_valid = 1'b0;
        {ext_write, ext_space, ext_addr, ext_wdata} = '0;
        prog_entry_pin_in = 1'b0;
        high_voltage_entry_level = 1'b0;
    end
    task automatic req(input logic w, input logic [1:0] sp, input logic [21:0] a,
                       input logic [7:0] d, output logic rf, output logic [7:0] q);
        @(posedge clk);
        ext_valid <= 1'b1;
        ext_write <= w;
        ext_space <= sp;
        ext_addr <= a;
        ext_wdata <= d;
        do @(posedge clk); while (ext_done !== 1'b1);
        rf = ext_refused;
        q = ext_rdata;
        ext_valid <= 1'b0;
        ext_addr <= ~a;
        ext_wdata <= ~d;
    endtask
    // master clear stays at normal level unless hv entry is wanted
    task automatic pins(input logic pin, input logic hv);
        @(posedge clk);
        prog_entry_pin_in <= pin;
        high_voltage_entry_level <= hv;
        repeat (6) @(posedge clk);
    endtask
endmodule // npe_prog_model
`default_nettype wire

// >>> tb/npe_nvm_protect_test.sv
/* self-checking bench of the nvm protection block.
   assumes the checker is bound and the programmer model drives the far side. */
`timescale 1ns/100ps
`default_nettype none
module npe_nvm_protect_test;
    logic        clk = 1'b0;
    logic        reset_n, avs_read, avs_write, avs_waitrequest, rf;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, user_prog_top, user_data_top, q;
    logic        ext_valid, ext_write, ext_done, ext_refused, high_voltage_entry_level;
    logic [1:0]  ext_space, dbg_pins_claimed, dbg_stack_levels;
    logic [21:0] ext_addr;
    logic [7:0]  ext_wdata, ext_rdata, q8;
    logic        prog_entry_pin_in, prog_entry_pin_out, prog_entry_pin_oe, dbg_enable;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #2.5 clk = ~clk;
    npe_nvm_protect i_npe_nvm_protect (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_valid, .ext_write, .ext_space,
        .ext_addr, .ext_wdata, .ext_done, .ext_refused, .ext_rdata, .prog_entry_pin_in,
        .prog_entry_pin_out, .prog_entry_pin_oe, .high_voltage_entry_level, .dbg_enable,
        .dbg_pins_claimed, .dbg_stack_levels, .user_prog_top, .user_data_top);
    npe_prog_model i_npe_prog_model (.clk, .ext_valid, .ext_write, .ext_space, .ext_addr,
        .ext_wdata, .ext_done, .ext_refused, .ext_rdata, .prog_entry_pin_in,
        .high_voltage_entry_level);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("avs_readdata", e, q);
    endtask
    task automatic pc(input logic w, input logic [1:0] sp, input logic [21:0] a,
                      input logic [7:0] d, input logic er, input logic [7:0] eq);
        i_npe_prog_model.req(w, sp, a, d, rf, q8);
        chk("ext_refused", {31'h0, er}, {31'h0, rf});
        if (!w) chk("ext_rdata", {24'h0, eq}, {24'h0, q8});
    endtask
    task automatic t_reset_debug();
        rd(npe_pkg::REG_CFG, 32'h0000001F);
        rd(12'h100, 32'h0);
        chk("debug", 32'h0, {27'h0, dbg_enable, dbg_pins_claimed, dbg_stack_levels});
        pc(1'b0, 2'h2, 22'h200000, 8'h00, 1'b1, 8'h00);
        bus(1'b1, npe_pkg::REG_CFG_CLR, 32'h000000E3);
        rd(npe_pkg::REG_CFG, 32'h00000417);
        chk("debug", 32'h1E, {27'h0, dbg_enable, dbg_pins_claimed, dbg_stack_levels});
        chk("tops", 32'h7DC007F6, {user_prog_top[15:0], user_data_top[15:0]});
        rd(npe_pkg::REG_DBG, 32'h0000000E);
    endtask
    task automatic t_low_volt();
        bus(1'b1, npe_pkg::REG_PIN, 32'h00000003);
        i_npe_prog_model.pins(1'b1, 1'b0);
        rd(npe_pkg::REG_CFG, 32'h00000517);
        chk("pin_oe", 32'h0, {31'h0, prog_entry_pin_oe});
        rd(npe_pkg::REG_PIN, 32'h0000000F);
        pc(1'b1, 2'h1, 22'h0, 8'h0F, 1'b0, 8'h00);
        rd(npe_pkg::REG_CFG, 32'h00000517);
        i_npe_prog_model.pins(1'b0, 1'b0);
    endtask
    task automatic t_high_volt();
        i_npe_prog_model.pins(1'b0, 1'b1);
        rd(npe_pkg::REG_CFG, 32'h00000717);
        pc(1'b1, 2'h2, 22'h200007, 8'hA5, 1'b0, 8'h00);
        rd(npe_pkg::ID_BASE + 12'h01C, 32'h000000A5);
        pc(1'b0, 2'h2, 22'h200008, 8'h00, 1'b1, 8'h00);
        pc(1'b1, 2'h0, 22'h000005, 8'h3C, 1'b0, 8'h00);
        pc(1'b1, 2'h0, 22'h000100, 8'h11, 1'b1, 8'h00);
        pc(1'b1, 2'h1, 22'h0, 8'h1D, 1'b0, 8'h00);
        pc(1'b1, 2'h0, 22'h000005, 8'h77, 1'b1, 8'h00);
        pc(1'b0, 2'h0, 22'h000005, 8'h00, 1'b0, 8'h3C);
        bus(1'b1, npe_pkg::EE_BASE + 12'h018, 32'h00000066);
        rd(npe_pkg::EE_BASE + 12'h018, 32'h00000066);
        pc(1'b1, 2'h1, 22'h0, 8'h1C, 1'b0, 8'h00);
        pc(1'b0, 2'h0, 22'h000005, 8'h00, 1'b1, 8'h00);
        rd(npe_pkg::EE_BASE + 12'h014, 32'h0000003C);
        pc(1'b0, 2'h2, 22'h200007, 8'h00, 1'b0, 8'hA5);
        pc(1'b1, 2'h1, 22'h0, 8'h1F, 1'b0, 8'h00);
        rd(npe_pkg::REG_CFG, 32'h00000714);
        pc(1'b1, 2'h1, 22'h0, 8'h1B, 1'b0, 8'h00);
        pc(1'b1, 2'h1, 22'h0, 8'h00, 1'b1, 8'h00);
        rd(npe_pkg::REG_CFG, 32'h00000710);
        pc(1'b0, 2'h3, 22'h0, 8'h00, 1'b1, 8'h00);
        pc(1'b1, 2'h3, 22'h0, 8'h00, 1'b0, 8'h00);
        rd(npe_pkg::REG_CFG, 32'h0000031F);
        rd(npe_pkg::EE_BASE + 12'h014, 32'h000000FF);
        pc(1'b1, 2'h1, 22'h0, 8'h0F, 1'b0, 8'h00);
        rd(npe_pkg::REG_CFG, 32'h0000030F);
    endtask
    task automatic t_lvp_off();
        i_npe_prog_model.pins(1'b0, 1'b0);
        rd(npe_pkg::REG_PIN, 32'h00000003);
        chk("pin_oe", 32'h1, {31'h0, prog_entry_pin_oe});
        chk("pin_out", 32'h1, {31'h0, prog_entry_pin_out});
        i_npe_prog_model.pins(1'b1, 1'b0);
        rd(npe_pkg::REG_CFG, 32'h0000000F);
        pc(1'b0, 2'h2, 22'h200000, 8'h00, 1'b1, 8'h00);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_debug();
        t_low_volt();
        t_high_volt();
        t_lvp_off();
        complete_run();
    end
endmodule // npe_nvm_protect_test
`default_nettype wire
